// ==== shared/lbc_pkg.sv ====
// Purpose: Shared constants and types of the lamp brightness control block.
// Assumes: 100 MHz system clock; analog levels arrive as unsigned ADC words.
// Notes:   Register offsets are byte addresses on the plain register port.
`default_nettype none
package lbc_pkg;
   // Brightness code.
   localparam int         CODE_W         = 5;
   localparam logic [4:0] CODE_MIN       = 5'h00;
   localparam logic [4:0] CODE_MAX       = 5'h1f;
   localparam logic [4:0] CODE_FLOOR_TOP = 5'h03;
   localparam logic [5:0] CODE_SPAN      = 6'h20;
   localparam logic [5:0] ADC_DIV        = 6'h21;
   localparam logic [5:0] ADC_UP_OFS     = 6'h02;
   localparam logic [7:0] CUR_DIV        = 8'ha0;
   // Chopping period in oscillator ticks, and duty steps in ticks.
   localparam logic [7:0] CHOP_TICKS     = 8'h80;
   localparam logic [7:0] DUTY_STEP      = 8'h04;
   localparam logic [7:0] DUTY_FLOOR     = 8'h0c;
   localparam logic [7:0] VLIM_TICKS     = 8'h04;
   // Timing.
   localparam int         CLK_HZ         = 100_000_000;
   localparam int         MS_PER_S       = 1000;
   localparam int         CHOP_NOM_HZ    = 210;
   localparam int         LAMP_OUT_MS    = 1000;
   localparam int         OSC_TICK_CYC_DEF = CLK_HZ / (CHOP_NOM_HZ * int'(CHOP_TICKS));
   localparam int         LAMP_OUT_CYC_DEF = (CLK_HZ / MS_PER_S) * LAMP_OUT_MS;
   // Register port.
   localparam int         ADDR_W         = 4;
   localparam int         DATA_W         = 16;
   localparam logic [3:0] REG_CTRL       = 4'h0;
   localparam logic [3:0] REG_STATUS     = 4'h4;
   localparam logic [3:0] REG_TARGET     = 4'h8;
   localparam logic [15:0] CTRL_RST      = 16'h0000;
   localparam int         CTRL_CODE_LSB  = 0;
   localparam int         CTRL_SHDN_BIT  = 5;
   localparam int         CTRL_SYNC_BIT  = 6;
   localparam int         ST_CODE_LSB    = 0;
   localparam int         ST_LAMP_BIT    = 5;
   localparam int         ST_SHORT_BIT   = 6;
   localparam int         ST_CHOP_BIT    = 7;
   localparam int         ST_MODE_LSB    = 8;
   localparam int         ST_SHDN_BIT    = 10;
   // Positions in the synchronised pin vector.
   localparam int         PIN_W          = 8;
   localparam int         PIN_SHORT      = 0;
   localparam int         PIN_LOW        = 1;
   localparam int         PIN_SHDN_N     = 2;
   localparam int         PIN_SYNC       = 3;
   localparam int         PIN_FLOOR_LSB  = 4;
   localparam int         PIN_MODE_LSB   = 6;

   typedef enum logic [1:0] {
      MODE_POS = 2'b00,
      MODE_NEG = 2'b01,
      MODE_DIG = 2'b10
   } lbc_mode_t;

   typedef enum logic [1:0] {
      FL_MIX    = 2'b00,
      FL_REF    = 2'b01,
      FL_SUPPLY = 2'b10
   } lbc_floor_t;

   typedef enum logic {
      CH_OFF = 1'b0,
      CH_ON  = 1'b1
   } lbc_chop_t;
endpackage
`default_nettype wire

// ==== shared/lbc_adc_if.sv ====
// Purpose: Carries ADC samples to the brightness converter and its code back.
// Assumes: Samples are taken on the system clock.
// Notes:   The code is registered inside the converter.
`default_nettype none
interface lbc_adc_if #(parameter int ADC_W = 10);
   logic             valid;
   logic             neg;
   logic [ADC_W-1:0] ctl;
   logic [ADC_W-1:0] crf;
   logic [4:0]       code;
   modport src (output valid, output neg, output ctl, output crf, input code);
   modport cnv (input valid, input neg, input ctl, input crf, output code);
endinterface
`default_nettype wire

// ==== rtl/lbc_code_adc.sv ====
// Purpose: Converts the control level into a brightness code with hysteresis.
// Assumes: One step per valid sample; a large jump settles over several samples.
// Notes:   Negative scale runs the positive logic on the mirrored code.
`default_nettype none
module lbc_code_adc
   import lbc_pkg::*;
#(
   parameter int ADC_W = 10
) (
   input  wire logic i_clk,
   input  wire logic i_rst,
   lbc_adc_if.cnv    adc
);
   localparam int PW = ADC_W + 6;

   logic [4:0] code_r;
   logic [4:0] m;
   logic       step_up;
   logic       step_dn;

   function automatic logic [PW-1:0] scaled(input logic [5:0] k, input logic [ADC_W-1:0] v);
      scaled = PW'(k) * PW'(v);
   endfunction

   assign m = adc.neg ? (CODE_MAX - code_r) : code_r;
   assign step_up = (m != CODE_MAX) &&
                    (scaled(ADC_DIV, adc.ctl) >= scaled({1'b0, m} + ADC_UP_OFS, adc.crf));
   assign step_dn = (m != CODE_MIN) &&
                    (scaled(ADC_DIV, adc.ctl) < scaled({1'b0, m}, adc.crf));

   // rising level raises code on positive scale.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         code_r <= CODE_MIN;
      end else if (adc.valid && (step_up != step_dn)) begin
         if (step_up != adc.neg) begin
            code_r <= code_r + 5'h01;
         end else begin
            code_r <= code_r - 5'h01;
         end
      end
   end
   assign adc.code = code_r;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   chk_hyst_single_step: assert property (
      adc.valid |=> ((code_r - $past(code_r)) == 5'h01) || ((($past(code_r) - code_r)) == 5'h01)
                    || $stable(code_r))
      else $error("converter moved more than one code");
   chk_pos_scale_up: assert property (
      (adc.valid && !adc.neg && adc.crf != '0 && adc.ctl >= adc.crf && code_r != CODE_MAX)
      |=> code_r == $past(code_r) + 5'h01)
      else $error("positive scale failed to rise at full input");
   chk_neg_scale_dn: assert property (
      (adc.valid && adc.neg && adc.crf != '0 && adc.ctl >= adc.crf && code_r != CODE_MIN)
      |=> code_r == $past(code_r) - 5'h01)
      else $error("negative scale failed to fall at full input");
   cov_code_top: cover property (adc.valid && !adc.neg ##1 code_r == CODE_MAX);
endmodule
`default_nettype wire

// ==== rtl/lbc_dimming_ctrl.sv ====
// Purpose: Brightness code, current target and chopping control of a lamp inverter.
// Assumes: Pin levels come from comparators; analog words from ADCs on I_CLK_SYS.
// Notes:   Analog loops and bridge drive are outside; this block steers them.
`default_nettype none
module lbc_dimming_ctrl
   import lbc_pkg::*;
#(
   parameter int ADC_W        = 10,
   parameter int LVL_W        = 8,
   parameter int OSC_TICK_CYC = lbc_pkg::OSC_TICK_CYC_DEF,
   parameter int LAMP_OUT_CYC = lbc_pkg::LAMP_OUT_CYC_DEF
) (
   // Clock and reset
   input  wire logic                       I_CLK_SYS,
   input  wire logic                       I_RST,
   // Register port
   input  wire logic [lbc_pkg::ADDR_W-1:0] I_ADDR,
   input  wire logic [lbc_pkg::DATA_W-1:0] I_WDATA,
   input  wire logic                       I_WR,
   input  wire logic                       I_RD,
   output logic      [lbc_pkg::DATA_W-1:0] O_RDATA,
   // Pins seen through comparators
   input  wire logic [1:0]                 I_MODE_STRAP,
   input  wire logic                       I_MODE_SYNC,
   input  wire logic [1:0]                 I_FLOOR_SEL,
   input  wire logic                       I_SHDN_SUSPEND_N,
   input  wire logic                       I_LAMP_LOW,
   input  wire logic                       I_SHORT_DET,
   // Converted analog levels
   input  wire logic                       I_ADC_VALID,
   input  wire logic [ADC_W-1:0]           I_CTL_LEVEL,
   input  wire logic [ADC_W-1:0]           I_SCALE_TOP,
   input  wire logic [LVL_W-1:0]           I_FLOOR_LEVEL,
   input  wire logic [LVL_W-1:0]           I_REF_LEVEL,
   // Loop and drive control
   output logic                            O_CHOP_PWM,
   output logic                            O_DRIVE_EN,
   output logic                            O_ILOOP_HOLD,
   output logic                            O_VLOOP_PRESET,
   output logic                            O_VLIM_EN,
   output logic                            O_LOOP_DISCHARGE,
   output logic      [LVL_W-1:0]           O_CUR_TARGET,
   output logic      [4:0]                 O_BRIGHT_CODE,
   // Status
   output logic                            O_LAMP_FAULT,
   output logic                            O_BUS_ACTIVE,
   output logic                            O_BUS_SUSPEND
);
   if (OSC_TICK_CYC < 2 || OSC_TICK_CYC > 65535) begin : g_bad_tick
      $error("OSC_TICK_CYC out of range");
   end
   if (LAMP_OUT_CYC < 2 || LVL_W < 2 || LVL_W > 16 || ADC_W < 2) begin : g_bad_par
      $error("width or timeout parameter out of range");
   end

   // Pin synchronisers.
   logic [PIN_W-1:0]  pin_raw;
   logic [PIN_W-1:0]  pin_s1_r;
   logic [PIN_W-1:0]  pin_s2_r;
   logic [PIN_W-1:0]  pin_s3_r;
   logic [PIN_W-1:0]  pin_r;
   logic [PIN_W-1:0]  pin_nxt;
   logic              sync_prev_r;

   // Control state.
   logic [DATA_W-1:0] ctrl_r;
   lbc_mode_t         mode;
   lbc_floor_t        floor_sel;
   logic              shutdown;
   logic              run;
   logic [4:0]        code_sel;
   logic [4:0]        code_r;
   logic [LVL_W-1:0]  floor_eff;
   logic [LVL_W-1:0]  target_r;

   // Chopping oscillator.
   logic [15:0]       div_r;
   logic              tick;
   logic [6:0]        chop_cnt_r;
   logic [6:0]        chop_cnt_nxt;
   logic              period_start;
   logic [7:0]        duty_r;
   logic [7:0]        duty_nxt;
   lbc_chop_t         chop_r;
   lbc_chop_t         chop_nxt;

   // Faults.
   logic [31:0]       low_cnt_r;
   logic              lamp_fault_r;
   logic              short_fault_r;
   logic              lamp_trip;

   // Outputs.
   logic              drive_r;
   logic              ihold_r;
   logic              vpreset_r;
   logic              vlim_r;
   logic              dischg_r;
   logic              susp_r;
   logic              bus_act_r;
   logic [DATA_W-1:0] rdata_r;

   lbc_adc_if #(.ADC_W(ADC_W)) adc_bus ();

   function automatic logic [LVL_W-1:0] cur_target(input logic [LVL_W-1:0] ref_l,
                                                   input logic [LVL_W-1:0] fl,
                                                   input logic [4:0]       n);
      logic [LVL_W+6:0] acc;
      acc = (LVL_W+7)'(ref_l) * (LVL_W+7)'(n) +
            (LVL_W+7)'(fl) * (LVL_W+7)'(CODE_SPAN - {1'b0, n});
      cur_target = LVL_W'(acc / (LVL_W+7)'(CUR_DIV));
   endfunction

   function automatic logic [7:0] duty_ticks(input logic [4:0] n, input lbc_floor_t fs);
      if (fs == FL_SUPPLY) begin
         duty_ticks = CHOP_TICKS;
      end else if (n <= CODE_FLOOR_TOP) begin
         duty_ticks = DUTY_FLOOR;
      end else begin
         duty_ticks = 8'(({3'h0, n} + 8'h01) * DUTY_STEP);
      end
   endfunction

   // A pin bit counts as changed once the second and third stages agree.
   assign pin_raw = {I_MODE_STRAP, I_FLOOR_SEL, I_MODE_SYNC, I_SHDN_SUSPEND_N,
                     I_LAMP_LOW, I_SHORT_DET};
   assign pin_nxt = (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r ^ pin_s3_r));

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         pin_s1_r    <= '0;
         pin_s2_r    <= '0;
         pin_s3_r    <= '0;
         pin_r       <= '0;
         sync_prev_r <= 1'b0;
      end else begin
         pin_s1_r    <= pin_raw;
         pin_s2_r    <= pin_s1_r;
         pin_s3_r    <= pin_s2_r;
         pin_r       <= pin_nxt;
         sync_prev_r <= pin_r[PIN_SYNC];
      end
   end

   // Register writes: only the control word is writable.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         ctrl_r <= CTRL_RST;
      end else if (I_WR && I_ADDR == REG_CTRL) begin
         ctrl_r <= I_WDATA;
      end
   end

   always_comb begin
      case (pin_r[PIN_MODE_LSB +: 2])
         MODE_NEG: mode = MODE_NEG;
         MODE_DIG: mode = MODE_DIG;
         default:  mode = MODE_POS;
      endcase
      case (pin_r[PIN_FLOOR_LSB +: 2])
         FL_REF:    floor_sel = FL_REF;
         FL_SUPPLY: floor_sel = FL_SUPPLY;
         default:   floor_sel = FL_MIX;
      endcase
   end

   assign shutdown = ctrl_r[CTRL_SHDN_BIT] || (mode != MODE_DIG && !pin_r[PIN_SHDN_N]);
   assign run      = !shutdown && !lamp_fault_r && !short_fault_r;

   // analog modes feed the converter from the control pin.
   assign adc_bus.valid = I_ADC_VALID && (mode != MODE_DIG);
   assign adc_bus.neg   = (mode == MODE_NEG);
   assign adc_bus.ctl   = I_CTL_LEVEL;
   assign adc_bus.crf   = I_SCALE_TOP;

   lbc_code_adc #(.ADC_W(ADC_W)) u_code_adc (
      .i_clk (I_CLK_SYS),
      .i_rst (I_RST),
      .adc   (adc_bus)
   );

   // one code from the selected interface.
   assign code_sel = (mode == MODE_DIG) ? ctrl_r[CTRL_CODE_LSB +: CODE_W] : adc_bus.code;
   // floor counts as zero when tied to supply.
   assign floor_eff = (floor_sel == FL_SUPPLY) ? '0 : I_FLOOR_LEVEL;

   // current target from code and floor.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         code_r   <= CODE_MIN;
         target_r <= '0;
      end else begin
         code_r   <= code_sel;
         target_r <= cur_target(I_REF_LEVEL, floor_eff, code_r);
      end
   end

   // tick from external sync edges or the internal divider.
   assign tick = ctrl_r[CTRL_SYNC_BIT] ? (pin_r[PIN_SYNC] && !sync_prev_r)
                                       : (div_r == 16'(OSC_TICK_CYC - 1));

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST || tick) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 16'h0001;
      end
   end

   assign period_start = tick && (chop_cnt_r == 7'(CHOP_TICKS - 8'h01));
   assign chop_cnt_nxt = tick ? (chop_cnt_r + 7'h01) : chop_cnt_r;
   // duty latched only at period start.
   assign duty_nxt     = period_start ? duty_ticks(code_r, floor_sel) : duty_r;
   assign chop_nxt     = ({1'b0, chop_cnt_nxt} < duty_nxt) ? CH_ON : CH_OFF;

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         chop_cnt_r <= '0;
         duty_r     <= CHOP_TICKS;
         chop_r     <= CH_ON;
      end else begin
         chop_cnt_r <= chop_cnt_nxt;
         duty_r     <= duty_nxt;
         chop_r     <= chop_nxt;
      end
   end

   // Lamp current is absent during off-periods, so the timer only runs while on.
   // timer restarts on any good sample.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST || !pin_r[PIN_LOW] || !run) begin
         low_cnt_r <= '0;
      end else if (chop_r == CH_ON && low_cnt_r != 32'(LAMP_OUT_CYC)) begin
         low_cnt_r <= low_cnt_r + 32'h0000_0001;
      end
   end
   assign lamp_trip = (low_cnt_r == 32'(LAMP_OUT_CYC));

   // lamp-out latch; a trip in the clearing cycle still sets.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         lamp_fault_r  <= 1'b0;
         short_fault_r <= 1'b0;
      end else begin
         lamp_fault_r  <= lamp_trip || (lamp_fault_r && !shutdown);
         short_fault_r <= pin_r[PIN_SHORT] || (short_fault_r && !shutdown);
      end
   end

   // voltage limit at on-start and open lamp.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         drive_r   <= 1'b0;
         ihold_r   <= 1'b0;
         vpreset_r <= 1'b0;
         vlim_r    <= 1'b0;
         dischg_r  <= 1'b1;
         susp_r    <= 1'b0;
         bus_act_r <= 1'b0;
      end else begin
         drive_r   <= run && (chop_nxt == CH_ON);
         ihold_r   <= run && (chop_nxt == CH_OFF);
         vpreset_r <= run && (chop_nxt == CH_OFF);
         vlim_r    <= run && (((chop_nxt == CH_ON) && ({1'b0, chop_cnt_nxt} < VLIM_TICKS))
                              || pin_r[PIN_LOW]);
         dischg_r  <= shutdown;
         susp_r    <= (mode == MODE_DIG) && !pin_r[PIN_SHDN_N];
         bus_act_r <= (mode == MODE_DIG);
      end
   end

   // Read data stand in the cycle after each cycle that I_RD is high and read zero otherwise; unmapped offsets read zero.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST || !I_RD) begin
         rdata_r <= '0;
      end else begin
         case (I_ADDR)
            REG_CTRL:   rdata_r <= ctrl_r;
            REG_STATUS: begin
               rdata_r                            <= '0;
               rdata_r[ST_CODE_LSB +: CODE_W]     <= code_r;
               rdata_r[ST_LAMP_BIT]               <= lamp_fault_r;
               rdata_r[ST_SHORT_BIT]              <= short_fault_r;
               rdata_r[ST_CHOP_BIT]               <= (chop_r == CH_ON);
               rdata_r[ST_MODE_LSB +: 2]          <= mode;
               rdata_r[ST_SHDN_BIT]               <= shutdown;
            end
            REG_TARGET: rdata_r <= DATA_W'(target_r);
            default:    rdata_r <= '0;
         endcase
      end
   end

   assign O_RDATA          = rdata_r;
   assign O_CHOP_PWM       = (chop_r == CH_ON);
   assign O_DRIVE_EN       = drive_r;
   assign O_ILOOP_HOLD     = ihold_r;
   assign O_VLOOP_PRESET   = vpreset_r;
   assign O_VLIM_EN        = vlim_r;
   assign O_LOOP_DISCHARGE = dischg_r;
   assign O_CUR_TARGET     = target_r;
   assign O_BRIGHT_CODE    = code_r;
   assign O_LAMP_FAULT     = lamp_fault_r;
   assign O_BUS_ACTIVE     = bus_act_r;
   assign O_BUS_SUSPEND    = susp_r;

   // Helper: ticks seen since the last period start.
   logic [7:0] tick_seen_r;
   logic       seen_start_r;
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST || period_start) begin
         tick_seen_r  <= '0;
         seen_start_r <= !I_RST;
      end else if (tick) begin
         tick_seen_r  <= tick_seen_r + 8'h01;
      end
   end

   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RST);

   chk_code_digital: assert property (
      (mode == MODE_DIG && $stable(ctrl_r)) [*3] |-> code_r == ctrl_r[CTRL_CODE_LSB +: CODE_W])
      else $error("digital code not taken from control word");
   chk_target_monotone: assert property (
      ($stable(I_REF_LEVEL) && $stable(floor_eff) && code_r > $past(code_r)
       && I_REF_LEVEL >= floor_eff) |=> target_r >= $past(target_r))
      else $error("current target fell with rising code");
   chk_target_floor: assert property (
      (code_r == CODE_MIN && $stable(code_r) && $stable(I_FLOOR_LEVEL) && floor_sel == FL_MIX)
      |=> target_r == LVL_W'((LVL_W+3)'($past(I_FLOOR_LEVEL)) / (LVL_W+3)'(5)))
      else $error("code zero target is not floor over five");
   chk_target_full: assert property (
      (floor_sel == FL_REF && I_FLOOR_LEVEL == I_REF_LEVEL && $stable(I_REF_LEVEL)
       && $stable(code_r)) |=> target_r == LVL_W'((LVL_W+3)'($past(I_REF_LEVEL)) / (LVL_W+3)'(5)))
      else $error("target not maximum with floor at reference");
   chk_duty_floor: assert property (
      (period_start && code_r <= CODE_FLOOR_TOP && floor_sel != FL_SUPPLY) |=> duty_r == DUTY_FLOOR)
      else $error("low codes did not give the floor duty");
   chk_duty_full: assert property (
      (period_start && floor_sel == FL_SUPPLY) |=> duty_r == CHOP_TICKS ##1 chop_r == CH_ON)
      else $error("supply floor did not force full duty");
   chk_lamp_out_stop: assert property (
      lamp_fault_r |=> !drive_r)
      else $error("drive still on after lamp-out");
   chk_timer_restart: assert property (
      !pin_r[PIN_LOW] |=> low_cnt_r == '0 && !lamp_trip)
      else $error("lamp-out timer did not restart");
   chk_off_hold: assert property (
      (run && chop_nxt == CH_OFF) |=> ihold_r && vpreset_r && !drive_r)
      else $error("off-period did not hold the loops");
   chk_vlim_start: assert property (
      (run && period_start && duty_nxt != '0) |=> vlim_r)
      else $error("voltage limit not active at on start");
   chk_period_len: assert property (
      (period_start && seen_start_r) |-> tick_seen_r == 8'(CHOP_TICKS - 8'h01))
      else $error("chopping period is not 128 ticks");
   chk_shdn_clear: assert property (
      (shutdown && !lamp_trip && !pin_r[PIN_SHORT]) |=> !lamp_fault_r && !short_fault_r)
      else $error("shutdown did not clear faults");
   chk_duty_latch: assert property (
      !period_start |=> $stable(duty_r))
      else $error("duty changed inside a period");
   chk_suspend_map: assert property (
      (mode == MODE_DIG && !ctrl_r[CTRL_SHDN_BIT])
      |-> !shutdown ##1 (susp_r == !$past(pin_r[PIN_SHDN_N])))
      else $error("suspend pin acted as shutdown in digital mode");

   cov_lamp_out: cover property ($rose(lamp_fault_r));
   cov_mixed_chop: cover property (floor_sel == FL_MIX && period_start ##1 chop_r == CH_OFF);
   cov_ext_sync: cover property (ctrl_r[CTRL_SYNC_BIT] && period_start);
endmodule
`default_nettype wire

// ==== verification/lbc_lvl_src.sv ====
// Purpose: Analog dimming source: control and scale-top words with samples.
// Assumes: One sample every eight clocks.
// Notes:   Scale top sits at full scale.
`default_nettype none
module lbc_lvl_src (
   input  wire logic       i_clk,
   input  wire logic [9:0] i_lvl,
   output logic            o_vld,
   output logic [9:0]      o_ctl,
   output logic [9:0]      o_top
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] cnt_r = 3'h0;
   always @(posedge i_clk) cnt_r <= cnt_r + 3'h1;
   assign o_vld = (cnt_r == 3'h7);
   assign o_ctl = i_lvl;
   assign o_top = 10'h3ff;
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Purpose: Self-checking bench of the dimming controller.
// Assumes: Short lamp-out and tick counts.
// Notes:   Expected targets are computed here.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, wr = 0, rd = 0, vld, low = 0, pwm, drv, flt;
   logic shn = 1, syn, hold, pre, vlim, dis, act, susp;
   logic [2:0] sc = 3'h0;
   time t0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wd = 16'h0, rdat, d;
   logic [1:0] strap = 2'h2, fsel = 2'h0;
   logic [7:0] fl = 8'h64, rf = 8'hc8, tgt;
   logic [9:0] ctl, top, lvl = 10'h0;
   logic [4:0] code, n;
   int fail_count = 0, n_checks = 0;
   lbc_lvl_src src (.i_clk(clk), .i_lvl(lvl), .o_vld(vld), .o_ctl(ctl), .o_top(top));
   lbc_dimming_ctrl #(.OSC_TICK_CYC(4), .LAMP_OUT_CYC(50)) dut (.I_CLK_SYS(clk),
      .I_RST(rst), .I_ADDR(addr), .I_WDATA(wd), .I_WR(wr), .I_RD(rd), .O_RDATA(rdat),
      .I_MODE_STRAP(strap), .I_MODE_SYNC(syn), .I_FLOOR_SEL(fsel),
      .I_SHDN_SUSPEND_N(shn), .I_LAMP_LOW(low), .I_SHORT_DET(1'b0), .I_ADC_VALID(vld),
      .I_CTL_LEVEL(ctl), .I_SCALE_TOP(top), .I_FLOOR_LEVEL(fl), .I_REF_LEVEL(rf),
      .O_CHOP_PWM(pwm), .O_DRIVE_EN(drv), .O_ILOOP_HOLD(hold), .O_VLOOP_PRESET(pre),
      .O_VLIM_EN(vlim), .O_LOOP_DISCHARGE(dis), .O_CUR_TARGET(tgt), .O_BRIGHT_CODE(code),
      .O_LAMP_FAULT(flt), .O_BUS_ACTIVE(act), .O_BUS_SUSPEND(susp));
   initial begin
      forever #5 clk = ~clk;
   end
   // External sync source: one rising edge every eight clocks, used once selected.
   always @(posedge clk) sc <= sc + 3'h1;
   assign syn = sc[2];
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wreg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a; wd <= v; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe.
   task rreg(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdat;
   endtask
   function logic [7:0] etgt(input logic [4:0] c, input logic [7:0] f);
      return 8'((int'(rf) * int'(c) + int'(f) * (32 - int'(c))) / 160);
   endfunction
   task summarize();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      summarize();
   end
   initial begin
      void'($urandom(15252));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1 chk({pwm, drv, flt}, 16'h4);
      repeat (8) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         n = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom % 32);
         fsel <= i[0] ? 2'h2 : {1'b0, i[1]};
         fl <= i[1] ? rf : 8'h64;
         wreg(4'h0, {11'h0, n});
         repeat (10) @(posedge clk);
         rreg(4'h4, d);
         chk(d[4:0], n);
         chk(code, n);
         chk(tgt, etgt(n, i[0] ? 8'h00 : fl));
         chk({dis, hold, pre, drv}, {13'h0, ~pwm, ~pwm, pwm});
      end
      rreg(4'hc, d);
      chk(d, 16'h0);
      strap <= 2'h0;
      lvl <= 10'h3ff;
      repeat (400) @(posedge clk);
      chk(code, 5'h1f);
      strap <= 2'h1;
      repeat (400) @(posedge clk);
      chk(code, 5'h00);
      shn <= 1'b0;
      repeat (8) @(posedge clk);
      chk({act, susp, dis}, 16'h1);
      strap <= 2'h2;
      repeat (8) @(posedge clk);
      chk({act, susp, dis}, 16'h6);
      shn <= 1'b1;
      fsel <= 2'h0;
      wreg(4'h0, 16'h001f);
      low <= 1'b1;
      repeat (10) @(posedge clk);
      chk(vlim, 1'b1);
      repeat (690) @(posedge clk);
      chk({flt, drv}, 16'h2);
      low <= 1'b0;
      wreg(4'h0, 16'h003f);
      repeat (3) @(posedge clk);
      chk({flt, dis}, 16'h1);
      // Code zero on external sync: 12 ticks on, 128 ticks of 8 clocks per period.
      wreg(4'h0, 16'h0040);
      @(posedge pwm);
      t0 = $time;
      @(negedge pwm);
      chk(16'(($time - t0) / 10), 16'h0060);
      @(posedge pwm);
      chk(16'(($time - t0) / 10), 16'h0400);
      summarize();
   end
endmodule
`default_nettype wire
